// ==== hw/elog_device.sv ====
// Encoder end of the fault history resource: logs faults, answers reads.
// Latches the request values on ctrl_wr, so the master need not hold them while a read runs.
//
// Operation
// - Defining values report sixteen-byte record size
// - Data type declared as code 20h
// - Faults indicated to drive and logged
// - Connection-failure faults are logged too
// - Full log overwrites the oldest record
// - Real-time-only faults may skip logging
// - Bytes 15,14 codes; 13,12 zero
// - Bytes 11..10 speed, 9..8 supply
// - Bytes 7..6 LED, 5..4 temperature
// - Bytes 3..0 hold fault time stamp
// - Records sequential, each reachable by offset
// - Master reads twice per full record
// - Offset zero returns stored record count
// - High offset byte selects record half
// - Low offset byte selects record, 1 newest
// - Master stays within record capacity
// - Master writes address, offset, control, waits
// - Master should read supplementary code
`timescale 1ns/1ps
`default_nettype none
`include "elog_map.svh"
module elog_device #(
	// Resource name returned at defining offset zero; value is arbitrary
	parameter logic [63:0] NAME_LABEL = 64'h4c48_5446_5f47_4f4c
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	// Fault report from encoder logic
	input wire logic FAULT_VALID,
	input wire logic FAULT_RT_ONLY,
	input wire logic FAULT_CONN,
	input wire logic [7:0] FAULT_CODE,
	input wire logic [7:0] FAULT_SUPP,
	input wire logic [15:0] SPEED_RPM,
	input wire logic [15:0] SUPPLY_MV,
	input wire logic [15:0] LED_CURRENT,
	input wire logic [15:0] TEMP_DECI,
	input wire logic [31:0] TIME_STAMP,
	// Fault indication and status
	output logic FAULT_IND,
	output logic FAULT_CONN_IND,
	output logic [7:0] LOG_COUNT,
	// Parameter channel
	elog_if.dev LINK
);
	elog_pkg::elog_rec_t wr_rec, rd_rec;
	logic log_wr, rd_ok;
	logic [7:0] count;
	logic ind_q, ind_d, conn_q, conn_d;
	logic [7:0] cnt_q, cnt_d;
	logic pend_q, pend_d, done_q, done_d, err_q, err_d;
	logic [7:0] addr_hi_q, addr_hi_d, addr_lo_q, addr_lo_d;
	logic [7:0] off_hi_q, off_hi_d, off_lo_q, off_lo_d;
	logic [7:0] ctrl_q, ctrl_d;
	elog_pkg::elog_msg_t data_q, data_d, resp;
	logic resp_err;

	// ==========================================
	// Defining values of the resource
	function automatic elog_pkg::elog_msg_t def_value(input logic [7:0] off);
		def_value = 64'h0;
		if (off == `ELOG_DEF_NAME) begin
			def_value = NAME_LABEL;
		end else if (off == `ELOG_DEF_SIZE) begin
			def_value = {56'h0, `ELOG_REC_SIZE};
		end else if (off == `ELOG_DEF_RDLVL) begin
			def_value = {56'h0, `ELOG_RD_LEVEL};
		end else if (off == `ELOG_DEF_WRLVL) begin
			def_value = {56'h0, `ELOG_WR_LEVEL};
		end else if (off == `ELOG_DEF_TOVR) begin
			def_value = {56'h0, `ELOG_TIME_OVR};
		end else if (off == `ELOG_DEF_TYPE) begin
			def_value = {56'h0, `ELOG_DATA_TYPE};
		end
	endfunction : def_value

	// ==========================================
	// Fault capture
	always_comb begin
		log_wr = FAULT_VALID && !FAULT_RT_ONLY;
		wr_rec = '0;
		wr_rec[`ELOG_POS_CODE +: 8] = FAULT_CODE;
		wr_rec[`ELOG_POS_SUPP +: 8] = FAULT_SUPP;
		wr_rec[`ELOG_POS_RSVD +: 16] = 16'h0000;
		wr_rec[`ELOG_POS_SPEED +: 16] = SPEED_RPM;
		wr_rec[`ELOG_POS_VOLT +: 16] = SUPPLY_MV;
		wr_rec[`ELOG_POS_LED +: 16] = LED_CURRENT;
		wr_rec[`ELOG_POS_TEMP +: 16] = TEMP_DECI;
		wr_rec[`ELOG_POS_TIME +: 32] = TIME_STAMP;
		ind_d = FAULT_VALID;
		conn_d = FAULT_VALID && FAULT_CONN;
		cnt_d = count;
	end

	elog_ring elog_ring_i (
		.clk(CLK),
		.reset(RESET),
		.ce(CE),
		.wr_en(log_wr),
		.wr_rec(wr_rec),
		.rd_num(off_lo_q),
		.rd_rec(rd_rec),
		.rd_ok(rd_ok),
		.count(count)
	);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ind_q <= 1'b0;
			conn_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (CE) begin
			ind_q <= ind_d;
			conn_q <= conn_d;
			cnt_q <= cnt_d;
		end
	end

	// ==========================================
	// Answer to a long-message read
	always_comb begin
		resp = 64'h0;
		resp_err = 1'b0;
		if (addr_hi_q != `ELOG_ADDR_HIGH || addr_lo_q != `ELOG_ADDR_LOW) begin
			resp_err = 1'b1;
		end else if (ctrl_q == `ELOG_CTRL_DEFS) begin
			resp = def_value(off_lo_q);
		end else if (ctrl_q != `ELOG_CTRL_READ) begin
			resp_err = 1'b1;
		end else if (off_lo_q == `ELOG_OFF_COUNT && off_hi_q == `ELOG_HALF_FIRST) begin
			resp = {56'h0, count};
		end else if (off_lo_q == `ELOG_OFF_COUNT) begin
			// Count has no second half; a refused answer carries no data
			resp_err = 1'b1;
		end else if (!rd_ok) begin
			// Beyond the stored records: nothing valid to return
			resp_err = 1'b1;
		end else if (off_hi_q == `ELOG_HALF_FIRST) begin
			resp = rd_rec[63:0];
		end else if (off_hi_q == `ELOG_HALF_SECOND) begin
			resp = rd_rec[127:64];
		end else begin
			resp_err = 1'b1;
		end
	end

	// ==========================================
	// Request latch and done flag
	always_comb begin
		addr_hi_d = addr_hi_q;
		addr_lo_d = addr_lo_q;
		off_hi_d = off_hi_q;
		off_lo_d = off_lo_q;
		ctrl_d = ctrl_q;
		pend_d = pend_q;
		done_d = done_q;
		err_d = err_q;
		data_d = data_q;
		if (LINK.ctrl_wr) begin
			// Latch so a late change of the request lines cannot tear the answer
			addr_hi_d = LINK.param_resource_addr_high;
			addr_lo_d = LINK.param_resource_addr_low;
			off_hi_d = LINK.param_offset_high;
			off_lo_d = LINK.param_offset_low;
			ctrl_d = LINK.param_request_control;
			pend_d = 1'b1;
			done_d = 1'b0;
		end else if (pend_q) begin
			pend_d = 1'b0;
			done_d = 1'b1;
			err_d = resp_err;
			data_d = resp;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			addr_hi_q <= `ELOG_RST_BYTE;
			addr_lo_q <= `ELOG_RST_BYTE;
			off_hi_q <= `ELOG_RST_BYTE;
			off_lo_q <= `ELOG_RST_BYTE;
			ctrl_q <= `ELOG_RST_BYTE;
			pend_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			data_q <= 64'h0;
		end else if (CE) begin
			addr_hi_q <= addr_hi_d;
			addr_lo_q <= addr_lo_d;
			off_hi_q <= off_hi_d;
			off_lo_q <= off_lo_d;
			ctrl_q <= ctrl_d;
			pend_q <= pend_d;
			done_q <= done_d;
			err_q <= err_d;
			data_q <= data_d;
		end
	end

	assign FAULT_IND = ind_q;
	assign FAULT_CONN_IND = conn_q;
	assign LOG_COUNT = cnt_q;
	assign LINK.transaction_done_flag = done_q;
	assign LINK.req_error = err_q;
	assign LINK.param_data_bytes = data_q;
endmodule : elog_device
`default_nettype wire

// ==== inc/elog_map.svh ====
// Constants of the fault history resource: link values, record layout, timing.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef ELOG_MAP_SVH
`define ELOG_MAP_SVH

// ==========================================
// Resource address and control values
`define ELOG_ADDR_HIGH 8'h7c
`define ELOG_ADDR_LOW 8'hcc
`define ELOG_CTRL_READ 8'h01
`define ELOG_CTRL_DEFS 8'h02
`define ELOG_HALF_FIRST 8'h00
`define ELOG_HALF_SECOND 8'h01
`define ELOG_OFF_COUNT 8'h00

// ==========================================
// Defining values
`define ELOG_DEF_NAME 8'h00
`define ELOG_DEF_SIZE 8'h01
`define ELOG_DEF_RDLVL 8'h02
`define ELOG_DEF_WRLVL 8'h03
`define ELOG_DEF_TOVR 8'h04
`define ELOG_DEF_TYPE 8'h05
`define ELOG_REC_SIZE 8'h10
`define ELOG_RD_LEVEL 8'h00
`define ELOG_WR_LEVEL 8'h0f
`define ELOG_TIME_OVR 8'h46
`define ELOG_DATA_TYPE 8'h20

// ==========================================
// Record byte positions (bit index of the low bit)
`define ELOG_POS_CODE 120
`define ELOG_POS_SUPP 112
`define ELOG_POS_RSVD 96
`define ELOG_POS_SPEED 80
`define ELOG_POS_VOLT 64
`define ELOG_POS_LED 48
`define ELOG_POS_TEMP 32
`define ELOG_POS_TIME 0

// ==========================================
// Capacity and reset values
`define ELOG_DEPTH 8
`define ELOG_PTR_W 3
`define ELOG_RST_BYTE 8'h00

`endif

// ==== inc/elog_pkg.sv ====
// Types shared by both ends of the fault history link.
// Assumes elog_map.svh holds every number.
`default_nettype none
package elog_pkg;
	typedef logic [7:0] elog_byte_t;
	typedef logic [63:0] elog_msg_t;
	typedef logic [127:0] elog_rec_t;
	typedef enum logic [1:0] {
		ELOG_IDLE,
		ELOG_ISSUE,
		ELOG_HOLD,
		ELOG_WAIT
	} elog_state_e;
endpackage : elog_pkg
`default_nettype wire

// ==== inc/elog_if.sv ====
// Parameter channel between the drive-side master and the encoder end.
// Assumes one clock shared by both ends; no tristate on this link.
`timescale 1ns/1ps
`default_nettype none
interface elog_if (input wire logic clk);
	logic [7:0] param_resource_addr_high;
	logic [7:0] param_resource_addr_low;
	logic [7:0] param_offset_high;
	logic [7:0] param_offset_low;
	logic [7:0] param_request_control;
	logic ctrl_wr;
	logic transaction_done_flag;
	logic req_error;
	elog_pkg::elog_msg_t param_data_bytes;

	modport dev (
		input clk,
		input param_resource_addr_high,
		input param_resource_addr_low,
		input param_offset_high,
		input param_offset_low,
		input param_request_control,
		input ctrl_wr,
		output transaction_done_flag,
		output req_error,
		output param_data_bytes
	);

	modport mst (
		input clk,
		output param_resource_addr_high,
		output param_resource_addr_low,
		output param_offset_high,
		output param_offset_low,
		output param_request_control,
		output ctrl_wr,
		input transaction_done_flag,
		input req_error,
		input param_data_bytes
	);
endinterface : elog_if
`default_nettype wire

// ==== hw/elog_ring.sv ====
// Ring of fault records held in flip-flops, newest addressed as number 1.
// Assumes the capacity is a power of two so the pointer wraps by itself.
`timescale 1ns/1ps
`default_nettype none
`include "elog_map.svh"
module elog_ring (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Write side
	input wire logic wr_en,
	input wire elog_pkg::elog_rec_t wr_rec,
	// Read side
	input wire logic [7:0] rd_num,
	output elog_pkg::elog_rec_t rd_rec,
	output logic rd_ok,
	output logic [7:0] count
);
	elog_pkg::elog_rec_t mem_q [`ELOG_DEPTH];
	elog_pkg::elog_rec_t mem_d [`ELOG_DEPTH];
	logic [`ELOG_PTR_W-1:0] ptr_q, ptr_d, rd_idx;
	logic [7:0] count_q, count_d;

	// ==========================================
	// Storage
	genvar g;
	generate
		for (g = 0; g < `ELOG_DEPTH; g++) begin : g_ent
			always_comb begin
				mem_d[g] = (wr_en && ptr_q == `ELOG_PTR_W'(g)) ? wr_rec : mem_q[g];
			end
			always_ff @(posedge clk) begin
				if (reset) begin
					mem_q[g] <= '0;
				end else if (ce) begin
					mem_q[g] <= mem_d[g];
				end
			end
		end
	endgenerate

	// ==========================================
	// Pointer and count
	always_comb begin
		ptr_d = ptr_q;
		count_d = count_q;
		if (wr_en) begin
			ptr_d = ptr_q + 1'b1;
			if (count_q < 8'(`ELOG_DEPTH)) begin
				count_d = count_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ptr_q <= '0;
			count_q <= 8'h00;
		end else if (ce) begin
			ptr_q <= ptr_d;
			count_q <= count_d;
		end
	end

	// ==========================================
	// Read by record number
	// Sequential addressing
	always_comb begin
		rd_idx = ptr_q - rd_num[`ELOG_PTR_W-1:0];
		rd_ok = (rd_num != 8'h00) && (rd_num <= count_q);
		rd_rec = rd_ok ? mem_q[rd_idx] : '0;
	end

	assign count = count_q;
endmodule : elog_ring
`default_nettype wire

// ==== hw/elog_master.sv ====
// Drive-side end: fetches the record count or one whole fault record.
// Assumes the encoder end answers on the shared clock.
`timescale 1ns/1ps
`default_nettype none
`include "elog_map.svh"
module elog_master (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	// User request
	input wire logic START,
	input wire logic [7:0] REC_NUM,
	// User answer
	output logic BUSY,
	output logic DONE,
	output logic ERR,
	output logic [7:0] COUNT,
	output logic [127:0] RECORD,
	output logic [7:0] FAULT_CODE,
	output logic [7:0] SUPP_CODE,
	// Parameter channel
	elog_if.mst LINK
);
	elog_pkg::elog_state_e st_q, st_d;
	logic busy_q, busy_d, done_q, done_d, err_q, err_d, wr_q, wr_d;
	logic [7:0] num_q, num_d, half_q, half_d, cnt_q, cnt_d, code_q, code_d, supp_q, supp_d;
	elog_pkg::elog_rec_t rec_q, rec_d;

	always_comb begin
		st_d = st_q;
		busy_d = busy_q;
		done_d = 1'b0;
		err_d = err_q;
		wr_d = 1'b0;
		num_d = num_q;
		half_d = half_q;
		cnt_d = cnt_q;
		code_d = code_q;
		supp_d = supp_q;
		rec_d = rec_q;
		case (st_q)
			elog_pkg::ELOG_IDLE: begin
				if (START) begin
					if (REC_NUM > 8'(`ELOG_DEPTH)) begin
						done_d = 1'b1;
						err_d = 1'b1;
					end else begin
						num_d = REC_NUM;
						half_d = `ELOG_HALF_FIRST;
						err_d = 1'b0;
						busy_d = 1'b1;
						wr_d = 1'b1;
						st_d = elog_pkg::ELOG_ISSUE;
					end
				end
			end
			elog_pkg::ELOG_ISSUE: begin
				// Done flag still shows the previous answer here
				st_d = elog_pkg::ELOG_HOLD;
			end
			elog_pkg::ELOG_HOLD: begin
				st_d = elog_pkg::ELOG_WAIT;
			end
			default: begin
				if (LINK.transaction_done_flag) begin
					if (LINK.req_error) begin
						err_d = 1'b1;
						done_d = 1'b1;
						busy_d = 1'b0;
						st_d = elog_pkg::ELOG_IDLE;
					end else if (num_q == `ELOG_OFF_COUNT) begin
						cnt_d = LINK.param_data_bytes[7:0];
						done_d = 1'b1;
						busy_d = 1'b0;
						st_d = elog_pkg::ELOG_IDLE;
					end else if (half_q == `ELOG_HALF_FIRST) begin
						rec_d[63:0] = LINK.param_data_bytes;
						half_d = `ELOG_HALF_SECOND;
						wr_d = 1'b1;
						st_d = elog_pkg::ELOG_ISSUE;
					end else begin
						rec_d[127:64] = LINK.param_data_bytes;
						code_d = LINK.param_data_bytes[`ELOG_POS_CODE-64 +: 8];
						supp_d = LINK.param_data_bytes[`ELOG_POS_SUPP-64 +: 8];
						done_d = 1'b1;
						busy_d = 1'b0;
						st_d = elog_pkg::ELOG_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st_q <= elog_pkg::ELOG_IDLE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			wr_q <= 1'b0;
			num_q <= 8'h00;
			half_q <= 8'h00;
			cnt_q <= 8'h00;
			code_q <= 8'h00;
			supp_q <= 8'h00;
			rec_q <= '0;
		end else if (CE) begin
			st_q <= st_d;
			busy_q <= busy_d;
			done_q <= done_d;
			err_q <= err_d;
			wr_q <= wr_d;
			num_q <= num_d;
			half_q <= half_d;
			cnt_q <= cnt_d;
			code_q <= code_d;
			supp_q <= supp_d;
			rec_q <= rec_d;
		end
	end

	assign BUSY = busy_q;
	assign DONE = done_q;
	assign ERR = err_q;
	assign COUNT = cnt_q;
	assign RECORD = rec_q;
	assign FAULT_CODE = code_q;
	assign SUPP_CODE = supp_q;
	assign LINK.param_resource_addr_high = `ELOG_ADDR_HIGH;
	assign LINK.param_resource_addr_low = `ELOG_ADDR_LOW;
	assign LINK.param_offset_high = half_q;
	assign LINK.param_offset_low = num_q;
	assign LINK.param_request_control = `ELOG_CTRL_READ;
	assign LINK.ctrl_wr = wr_q;
endmodule : elog_master
`default_nettype wire

// ==== test/elog_asserts.sv ====
// Checker on the parameter channel between the master end and the encoder end.
// Assumes CE held high, so no frozen cycles on the channel.
`timescale 1ns/1ps
`default_nettype none
module elog_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic RESET,
	// Request side
	input wire logic [7:0] param_offset_high,
	input wire logic [7:0] param_offset_low,
	input wire logic ctrl_wr,
	// Answer side
	input wire logic transaction_done_flag,
	input wire logic req_error,
	input wire elog_pkg::elog_msg_t param_data_bytes
);
	wire dn = transaction_done_flag;
	wire er = req_error;
	wire [63:0] dat = param_data_bytes;
	logic [7:0] oh_q;
	logic [7:0] ol_q;
	logic [7:0] cnt_q;
	// ==========================================
	// Request memory; the count only grows, so it is a safe lower bound
	always_ff @(posedge clk) begin
		if (RESET) begin
			oh_q <= 8'h00;
			ol_q <= 8'h00;
			cnt_q <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				oh_q <= param_offset_high;
				ol_q <= param_offset_low;
			end
			if (dn && !er && ol_q == 8'h00) begin
				cnt_q <= dat[7:0];
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (RESET);
	// ==========================================
	// Answer timing and content
	AST_ANSWER_LAT: assert property (ctrl_wr |=> !dn ##1 dn)
		else $error("answer not in second cycle");
	AST_ANSWER_HOLD: assert property (dn && !ctrl_wr |=> dn && $stable(dat) && $stable(er))
		else $error("answer did not stand");
	AST_COUNT_FMT: assert property (dn && ol_q == 8'h00 && !er |-> dat[63:8] == 56'h0 && dat[7:0] <= 8'h08)
		else $error("count answer malformed");
	AST_COUNT_OK: assert property (dn && ol_q == 8'h00 && oh_q == 8'h00 |-> !er)
		else $error("count read refused");
	AST_RSVD_ZERO: assert property (dn && ol_q != 8'h00 && oh_q == 8'h01 && !er |-> dat[47:32] == 16'h0000)
		else $error("reserved bytes not zero");
	AST_REC_OK: assert property (dn && ol_q != 8'h00 && ol_q <= cnt_q |-> !er)
		else $error("stored record refused");
	AST_ERR_DATA: assert property (dn && er |-> dat == 64'h0)
		else $error("refused answer carries data");
	AST_RESET_QUIET: assert property ($fell(RESET) |-> !dn && !er)
		else $error("answer flags set after reset");
endmodule : elog_asserts
`default_nettype wire

// ==== test/test_encoder_error_log_access.sv ====
// Bench: both ends meet on one channel; a bench driver works a second encoder
// end with requests that the master never makes and two that it does. Assumes capacity of eight.
`timescale 1ns/1ps
`default_nettype none
module test_encoder_error_log_access;
	logic clk = 1'b0;
	logic RESET = 1'b1;
	logic fault_valid = 1'b0, fault_rt_only = 1'b0, fault_conn = 1'b0, start = 1'b0;
	logic [7:0] fault_code = 8'h00, fault_supp = 8'h00, rec_num = 8'h00;
	logic [15:0] speed = 16'h0000, supply = 16'h0000, led = 16'h0000, temp = 16'h0000;
	logic [31:0] tstamp = 32'h0;
	logic fault_ind, conn_ind, done, err, busy;
	logic ce_b = 1'b1;
	logic [7:0] log_count, count, fcode, scode;
	logic [127:0] record;
	logic [127:0] model[$];
	int err_total = 0;
	int samples_checked = 0;
	elog_if link (.clk(clk));
	elog_if link2 (.clk(clk));
	always #2.5 clk = ~clk;
	elog_device elog_device_i (.CLK(clk), .RESET(RESET), .CE(1'b1), .FAULT_VALID(fault_valid),
		.FAULT_RT_ONLY(fault_rt_only), .FAULT_CONN(fault_conn), .FAULT_CODE(fault_code), .FAULT_SUPP(fault_supp),
		.SPEED_RPM(speed), .SUPPLY_MV(supply), .LED_CURRENT(led), .TEMP_DECI(temp), .TIME_STAMP(tstamp),
		.FAULT_IND(fault_ind), .FAULT_CONN_IND(conn_ind), .LOG_COUNT(log_count), .LINK(link));
	// Second encoder end faces the bench driver only
	elog_device elog_device_b_i (.CLK(clk), .RESET(RESET), .CE(ce_b), .FAULT_VALID(fault_valid),
		.FAULT_RT_ONLY(fault_rt_only), .FAULT_CONN(fault_conn), .FAULT_CODE(fault_code), .FAULT_SUPP(fault_supp),
		.SPEED_RPM(speed), .SUPPLY_MV(supply), .LED_CURRENT(led), .TEMP_DECI(temp), .TIME_STAMP(tstamp),
		.FAULT_IND(), .FAULT_CONN_IND(), .LOG_COUNT(), .LINK(link2));
	elog_master elog_master_i (.CLK(clk), .RESET(RESET), .CE(1'b1), .START(start), .REC_NUM(rec_num), .BUSY(busy),
		.DONE(done), .ERR(err), .COUNT(count), .RECORD(record), .FAULT_CODE(fcode), .SUPP_CODE(scode), .LINK(link));
	elog_asserts elog_asserts_i (.clk(clk), .RESET(RESET), .param_offset_high(link.param_offset_high),
		.param_offset_low(link.param_offset_low), .ctrl_wr(link.ctrl_wr),
		.transaction_done_flag(link.transaction_done_flag), .req_error(link.req_error),
		.param_data_bytes(link.param_data_bytes));
	// ==========================================
	// Reporting
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_up(input int k);
		if (k >= 20) begin
			err_total++;
			print_verdict();
		end
	endtask : give_up
	// ==========================================
	// Drivers
	task automatic fault(input logic rt, input logic cn);
		int t;
		t = $urandom_range(12730) - 2730;
		@(posedge clk);
		fault_valid <= 1'b1;
		fault_rt_only <= rt;
		fault_conn <= cn;
		fault_code <= 8'($urandom);
		fault_supp <= 8'($urandom);
		speed <= 16'($urandom);
		supply <= 16'($urandom);
		led <= 16'($urandom);
		temp <= 16'(t);
		tstamp <= $urandom;
		@(posedge clk);
		fault_valid <= 1'b0;
		#1;
		chk(fault_ind, 1'b1);
		chk(conn_ind, cn);
		if (!rt) model.push_front({fault_code, fault_supp, 16'h0000, speed, supply, led, temp, tstamp});
		if (model.size() > 8) model.delete(8);
	endtask : fault
	task automatic mreq(input logic [7:0] rec);
		int k;
		@(posedge clk);
		start <= 1'b1;
		rec_num <= rec;
		@(posedge clk);
		start <= 1'b0;
		#1;
		chk(busy, rec <= 8'h08);
		for (k = 0; k < 20; k++) begin
			if (done === 1'b1) break;
			@(posedge clk);
			#1;
		end
		give_up(k);
		chk(busy, 1'b0);
	endtask : mreq
	task automatic read_all;
		mreq(8'h00);
		chk(count, model.size());
		chk(log_count, model.size());
		for (int r = 1; r <= 9; r++) begin
			mreq(8'(r));
			chk(err, r > model.size());
			if (r <= model.size()) begin
				chk(record, model[r - 1]);
				chk({fcode, scode}, model[r - 1][127:112]);
			end
		end
	endtask : read_all
	task automatic lreq(input logic [39:0] req, input logic eerr, input logic [7:0] ebyte);
		int k;
		@(posedge clk);
		{link2.param_resource_addr_high, link2.param_resource_addr_low, link2.param_offset_high,
			link2.param_offset_low, link2.param_request_control} <= req;
		link2.ctrl_wr <= 1'b1;
		@(posedge clk);
		link2.ctrl_wr <= 1'b0;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			#1;
			if (link2.transaction_done_flag === 1'b1) break;
		end
		give_up(k);
		chk(link2.req_error, eerr);
		chk(link2.param_data_bytes[7:0], ebyte);
	endtask : lreq
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hc6de));
		{link2.param_resource_addr_high, link2.param_resource_addr_low, link2.param_offset_high,
			link2.param_offset_low, link2.param_request_control} = 40'h0;
		link2.ctrl_wr = 1'b0;
		repeat (2) @(posedge clk);
		RESET <= 1'b0;
		read_all();
		$display("Test empty log done");
		for (int n = 0; n < 5; n++) fault(n == 2, n[0]);
		read_all();
		$display("Test partial log done");
		for (int n = 0; n < 9; n++) fault(n % 5 == 2, n[0]);
		read_all();
		$display("Test full log done");
		lreq(40'h7ccc000102, 1'b0, 8'h10);
		lreq(40'h7ccc000502, 1'b0, 8'h20);
		lreq(40'h7ccd000101, 1'b1, 8'h00);
		lreq(40'h7dcc000101, 1'b1, 8'h00);
		lreq(40'h7ccc000103, 1'b1, 8'h00);
		lreq(40'h7ccc020101, 1'b1, 8'h00);
		lreq(40'h7ccc010001, 1'b1, 8'h00);
		lreq(40'h7ccc000901, 1'b1, 8'h00);
		lreq(40'h7ccc000001, 1'b0, 8'h08);
		lreq(40'h7ccc010101, 1'b0, model[0][71:64]);
		// Clock enable low: request not taken, last answer stands
		@(posedge clk);
		ce_b <= 1'b0;
		lreq(40'h7ccc000001, 1'b0, model[0][71:64]);
		ce_b <= 1'b1;
		$display("Test link refusals done");
		print_verdict();
	end
endmodule : test_encoder_error_log_access
`default_nettype wire
